/* logic/dti_cfg.svh */
`ifndef DTI_CFG_SVH
`define DTI_CFG_SVH
// register indices; byte address is four times the index
`define DTI_IDX_LOW_CMP 8'h22
`define DTI_IDX_HIGH_CMP 8'h23
`define DTI_IDX_RUN 8'h20
`define DTI_IDX_MODE 8'h24
`define DTI_IDX_TOGGLE 8'h25
`define DTI_IDX_SYSCLK 8'h26
`define DTI_IDX_STATUS 8'h27
// run_ctrl_reg fields
`define DTI_RUN_T0 0
`define DTI_RUN_T1 1
`define DTI_RUN_PRE 7
// timer_mode_reg fields
`define DTI_MODE_T0SRC 1:0
`define DTI_MODE_T1SRC 3:2
`define DTI_MODE_PAIR 5:4
// toggle_ctrl_reg fields
`define DTI_TOG_FORCE 1:0
`define DTI_TOG_INV_EN 2
`define DTI_TOG_SEL 3
`define DTI_TOG_DBUF 6
// sysclk_ctrl_zero fields
`define DTI_SYS_PRESRC 1:0
// reset values
`define DTI_RST_RUN 8'h00
`define DTI_RST_MODE 8'h00
`define DTI_RST_TOGGLE 8'h03
`define DTI_RST_SYSCLK 8'h00
// axi responses
`define DTI_RESP_OKAY 2'h0
`define DTI_RESP_SLVERR 2'h2
`endif

/* logic/dti_pkg.sv */
package dti_pkg;
  // pair operating mode, field encoding
  typedef enum logic [1:0] {
    DTI_MODE_8BIT = 2'h0,
    DTI_MODE_16BIT = 2'h1,
    DTI_MODE_PPG = 2'h2,
    DTI_MODE_PWM = 2'h3
  } dti_mode_t;
  // prescaler source encoding
  typedef enum logic [1:0] {
    DTI_PSRC_GEAR = 2'h0,
    DTI_PSRC_LOW = 2'h1,
    DTI_PSRC_HIGH16 = 2'h2,
    DTI_PSRC_RSVD = 2'h3
  } dti_psrc_t;
  // toggle force field encoding
  typedef enum logic [1:0] {
    DTI_TOG_INVERT = 2'h0,
    DTI_TOG_CLEAR = 2'h1,
    DTI_TOG_SET = 2'h2,
    DTI_TOG_KEEP = 2'h3
  } dti_tog_t;
endpackage

/* logic/dti_timer.sv */
`timescale 1ns/1ps
`include "dti_cfg.svh"
// Function
// - two 8-bit timers, cascadable to 16 bits
// - four modes: 8bit, 16bit, ppg, pwm
// - per-timer counter, comparator, register; shared toggle
// - 9-bit prescaler makes four ticks
// - prescaler fed by selected source divided by four
// - reset selects geared clock source
// - tick periods source times 8,32,128,2048
// - prescaler run bit starts; clear zeroes, halts
// - timer 0 counts pin or three fastest ticks
// - timer 1 counts overflow, tick or match
// - pair mode 01 cascade, 00 eight-bit default
// - run bits start, stop, clear counters
// - match on equality; zero compare matches overflow
// - dbuf_enable gates timer 0 compare buffer
// - buffer loads at pwm overflow, ppg cycle
// - shared address; buffered write updates buffer only
// - compare registers write-only at their addresses
// - match clears counter in 8bit and 16bit modes (ppg clears at cycle end, pwm runs free); raises timer interrupt
// - toggle inverts with match when enabled
// - low byte write suspends compare until high
// - force field clears, sets or inverts toggle
module dti_timer
  import dti_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic geared_clock,
  input wire logic low_osc,
  input wire logic high_osc,
  input wire logic ext_count_in,
  output logic shared_toggle_ff,
  output logic first_timer_irq,
  output logic second_timer_irq
);

  // ==========================================================
  // register bus
  logic [7:0] aw_idx_reg;
  logic aw_held_reg;
  logic [7:0] w_data_reg;
  logic w_strb_reg;
  logic w_held_reg;
  logic [7:0] run_ctrl_reg;
  logic [7:0] timer_mode_reg;
  logic [7:0] toggle_ctrl_reg;
  logic [7:0] sysclk_ctrl_zero;
  logic [7:0] low_compare_value;
  logic [7:0] low_compare_buf;
  logic [7:0] high_compare_value;
  logic cmp_suspend_reg;
  logic wr_fire;
  logic wr_ok;
  logic [7:0] ar_idx;

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_ok = (aw_idx_reg == `DTI_IDX_LOW_CMP) || (aw_idx_reg == `DTI_IDX_HIGH_CMP) ||
    (aw_idx_reg == `DTI_IDX_RUN) || (aw_idx_reg == `DTI_IDX_MODE) ||
    (aw_idx_reg == `DTI_IDX_TOGGLE) || (aw_idx_reg == `DTI_IDX_SYSCLK) ||
    (aw_idx_reg == `DTI_IDX_STATUS);
  assign ar_idx = {2'h0, s_axi_araddr[7:2]};

  // address and data are taken in either order and held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_idx_reg <= {2'h0, s_axi_awaddr[7:2]};
      s_axi_awready <= 1'b0;
    end else begin
      if (wr_fire) aw_held_reg <= 1'b0;
      s_axi_awready <= !aw_held_reg && !s_axi_bvalid && !s_axi_awready;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata[7:0];
      w_strb_reg <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else begin
      if (wr_fire) w_held_reg <= 1'b0;
      s_axi_wready <= !w_held_reg && !s_axi_bvalid && !s_axi_wready;
    end
  end

  // response follows both halves; unmapped index answers slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DTI_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `DTI_RESP_OKAY : `DTI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_en;
  assign wr_en = wr_fire && w_strb_reg;

  // plain control registers; only the low byte lane carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_ctrl_reg <= `DTI_RST_RUN;
      timer_mode_reg <= `DTI_RST_MODE;
      toggle_ctrl_reg <= `DTI_RST_TOGGLE;
      sysclk_ctrl_zero <= `DTI_RST_SYSCLK;
    end else if (wr_en) begin
      if (aw_idx_reg == `DTI_IDX_RUN) run_ctrl_reg <= w_data_reg;
      if (aw_idx_reg == `DTI_IDX_MODE) timer_mode_reg <= w_data_reg;
      if (aw_idx_reg == `DTI_IDX_TOGGLE) toggle_ctrl_reg <= w_data_reg;
      if (aw_idx_reg == `DTI_IDX_SYSCLK) sysclk_ctrl_zero <= w_data_reg;
    end
  end

  dti_mode_t pair_mode_sel;
  logic dbuf_enable;
  logic buf_load;
  assign pair_mode_sel = dti_mode_t'(timer_mode_reg[`DTI_MODE_PAIR]);
  assign dbuf_enable = toggle_ctrl_reg[`DTI_TOG_DBUF];

  // compare registers, with the timer 0 buffer behind one address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_compare_value <= 8'h00;
      low_compare_buf <= 8'h00;
      high_compare_value <= 8'h00;
    end else begin
      if (wr_en && aw_idx_reg == `DTI_IDX_LOW_CMP) begin
        low_compare_buf <= w_data_reg;
        if (!dbuf_enable) low_compare_value <= w_data_reg;
      end else if (buf_load) begin
        low_compare_value <= low_compare_buf;
      end
      if (wr_en && aw_idx_reg == `DTI_IDX_HIGH_CMP) high_compare_value <= w_data_reg;
    end
  end

  // low byte write parks the 16-bit comparator until the high byte lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_suspend_reg <= 1'b0;
    end else if (wr_en && aw_idx_reg == `DTI_IDX_HIGH_CMP) begin
      cmp_suspend_reg <= 1'b0;
    end else if (wr_en && aw_idx_reg == `DTI_IDX_LOW_CMP) begin
      cmp_suspend_reg <= 1'b1;
    end
  end

  // ==========================================================
  // prescaler
  logic ext_sync1_reg;
  logic ext_sync2_reg;
  logic ext_last_reg;
  logic gear_last_reg;
  logic low_last_reg;
  logic high_last_reg;
  logic [3:0] high_div_reg;
  logic [1:0] pre_div4_reg;
  logic [8:0] pre_cnt_reg;
  logic src_pulse;
  logic pre_in;
  logic prescaler_run;
  logic tick_div8;
  logic tick_div32;
  logic tick_div128;
  logic tick_div2048;
  logic ext_pulse;

  assign prescaler_run = run_ctrl_reg[`DTI_RUN_PRE];

  // external pin synchronised before edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      ext_last_reg <= 1'b0;
    end else begin
      ext_sync1_reg <= ext_count_in;
      ext_sync2_reg <= ext_sync1_reg;
      ext_last_reg <= ext_sync2_reg;
    end
  end
  assign ext_pulse = ext_sync2_reg && !ext_last_reg;

  // source clocks arrive as levels; rising edges become enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gear_last_reg <= 1'b0;
      low_last_reg <= 1'b0;
      high_last_reg <= 1'b0;
      high_div_reg <= 4'h0;
    end else begin
      gear_last_reg <= geared_clock;
      low_last_reg <= low_osc;
      high_last_reg <= high_osc;
      if (high_osc && !high_last_reg) high_div_reg <= high_div_reg + 4'h1;
    end
  end

  // reserved source code gives no count; that code is software's to avoid
  always_comb begin
    case (dti_psrc_t'(sysclk_ctrl_zero[`DTI_SYS_PRESRC]))
      DTI_PSRC_GEAR: src_pulse = geared_clock && !gear_last_reg;
      DTI_PSRC_LOW: src_pulse = low_osc && !low_last_reg;
      DTI_PSRC_HIGH16: src_pulse = high_osc && !high_last_reg && (&high_div_reg);
      default: src_pulse = 1'b0;
    endcase
  end
  assign pre_in = prescaler_run && src_pulse && (&pre_div4_reg);

  // stopping zeroes both the divide-by-four stage and the 9-bit count
  always_ff @(posedge aclk) begin
    if (!aresetn || !prescaler_run) begin
      pre_div4_reg <= 2'h0;
      pre_cnt_reg <= 9'h000;
    end else begin
      if (src_pulse) pre_div4_reg <= pre_div4_reg + 2'h1;
      if (pre_in) pre_cnt_reg <= pre_cnt_reg + 9'h001;
    end
  end

  // ticks at source times 8, 32, 128 and 2048
  assign tick_div8 = pre_in && pre_cnt_reg[0];
  assign tick_div32 = pre_in && (&pre_cnt_reg[2:0]);
  assign tick_div128 = pre_in && (&pre_cnt_reg[4:0]);
  assign tick_div2048 = pre_in && (&pre_cnt_reg[8:0]);

  // ==========================================================
  // up counters and comparators
  logic [7:0] cnt0_reg;
  logic [7:0] cnt1_reg;
  logic [7:0] cnt0_inc;
  logic [7:0] cnt1_inc;
  logic [15:0] cnt16_inc;
  logic t0_tick;
  logic t1_tick;
  logic t0_ovf;
  logic match0;
  logic match1;
  logic match16;
  logic cycle_end;
  logic run0;
  logic run1;

  assign run0 = run_ctrl_reg[`DTI_RUN_T0];
  assign run1 = run_ctrl_reg[`DTI_RUN_T1];
  assign cnt0_inc = cnt0_reg + 8'h01;
  assign cnt1_inc = cnt1_reg + 8'h01;
  assign cnt16_inc = {cnt1_reg, cnt0_reg} + 16'h0001;

  // timer 0 source: pin or the three fastest ticks
  always_comb begin
    case (timer_mode_reg[`DTI_MODE_T0SRC])
      2'h0: t0_tick = ext_pulse;
      2'h1: t0_tick = tick_div8;
      2'h2: t0_tick = tick_div32;
      default: t0_tick = tick_div128;
    endcase
  end

  // equality on the incremented count also covers a zero compare
  assign t0_ovf = run0 && t0_tick && (cnt0_reg == 8'hFF);
  assign match0 = run0 && t0_tick && (cnt0_inc == low_compare_value);
  assign match16 = run0 && run1 && t0_tick && !cmp_suspend_reg &&
    (cnt16_inc == {high_compare_value, low_compare_value});
  assign cycle_end = (pair_mode_sel == DTI_MODE_PPG) ? run0 && t0_tick &&
    (cnt0_inc == high_compare_value) : t0_ovf;

  // timer 1 source depends on the pair mode
  always_comb begin
    if (pair_mode_sel == DTI_MODE_16BIT) begin
      t1_tick = t0_ovf;
    end else begin
      case (timer_mode_reg[`DTI_MODE_T1SRC])
        2'h0: t1_tick = match0;
        2'h1: t1_tick = tick_div8;
        2'h2: t1_tick = tick_div128;
        default: t1_tick = tick_div2048;
      endcase
    end
  end
  assign match1 = run1 && t1_tick && (cnt1_inc == high_compare_value);

  // buffer moves only in the pulse modes
  assign buf_load = dbuf_enable && cycle_end &&
    (pair_mode_sel == DTI_MODE_PPG || pair_mode_sel == DTI_MODE_PWM);

  // a stopped timer is held at zero
  always_ff @(posedge aclk) begin
    if (!aresetn || !run0) begin
      cnt0_reg <= 8'h00;
    end else if (t0_tick) begin
      case (pair_mode_sel)
        DTI_MODE_8BIT: cnt0_reg <= match0 ? 8'h00 : cnt0_inc;
        DTI_MODE_16BIT: cnt0_reg <= match16 ? 8'h00 : cnt0_inc;
        DTI_MODE_PPG: cnt0_reg <= cycle_end ? 8'h00 : cnt0_inc;
        default: cnt0_reg <= cnt0_inc;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run1) begin
      cnt1_reg <= 8'h00;
    end else if (pair_mode_sel == DTI_MODE_16BIT) begin
      if (match16) cnt1_reg <= 8'h00;
      else if (t1_tick) cnt1_reg <= cnt1_inc;
    end else if (pair_mode_sel == DTI_MODE_8BIT && t1_tick) begin
      cnt1_reg <= match1 ? 8'h00 : cnt1_inc;
    end
  end

  // ==========================================================
  // interrupts and toggle
  logic irq0_next;
  logic irq1_next;
  logic tog_hw;
  logic tog_sw;
  dti_tog_t tog_cmd;

  always_comb begin
    case (pair_mode_sel)
      DTI_MODE_8BIT: begin
        irq0_next = match0;
        irq1_next = match1;
        tog_hw = toggle_ctrl_reg[`DTI_TOG_SEL] ? match1 : match0;
      end
      DTI_MODE_16BIT: begin
        irq0_next = match0;
        irq1_next = match16;
        tog_hw = match16;
      end
      default: begin
        irq0_next = match0;
        irq1_next = 1'b0;
        tog_hw = match0 || cycle_end;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_timer_irq <= 1'b0;
      second_timer_irq <= 1'b0;
    end else begin
      first_timer_irq <= irq0_next;
      second_timer_irq <= irq1_next;
    end
  end

  assign tog_sw = wr_en && aw_idx_reg == `DTI_IDX_TOGGLE;
  assign tog_cmd = dti_tog_t'(w_data_reg[`DTI_TOG_FORCE]);

  // software force wins over a match in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_toggle_ff <= 1'b0;
    end else if (tog_sw && tog_cmd != DTI_TOG_KEEP) begin
      case (tog_cmd)
        DTI_TOG_CLEAR: shared_toggle_ff <= 1'b0;
        DTI_TOG_SET: shared_toggle_ff <= 1'b1;
        default: shared_toggle_ff <= !shared_toggle_ff;
      endcase
    end else if (toggle_ctrl_reg[`DTI_TOG_INV_EN] && tog_hw) begin
      shared_toggle_ff <= !shared_toggle_ff;
    end
  end

  // ==========================================================
  // read path; compare registers read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DTI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `DTI_RESP_OKAY;
      case (ar_idx)
        `DTI_IDX_RUN: s_axi_rdata <= {24'h000000, run_ctrl_reg};
        `DTI_IDX_MODE: s_axi_rdata <= {24'h000000, timer_mode_reg};
        `DTI_IDX_TOGGLE: s_axi_rdata <= {24'h000000, toggle_ctrl_reg};
        `DTI_IDX_SYSCLK: s_axi_rdata <= {24'h000000, sysclk_ctrl_zero};
        `DTI_IDX_STATUS: s_axi_rdata <= {14'h0000, cmp_suspend_reg, shared_toggle_ff,
          cnt1_reg, cnt0_reg};
        `DTI_IDX_LOW_CMP, `DTI_IDX_HIGH_CMP: s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `DTI_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready;
    end
  end

endmodule

/* tb/dti_timer_checker.sv */
`timescale 1ns/1ps
// ==========================================
// bus handshake and interrupt pulse checks
module dti_timer_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic first_timer_irq,
  input wire logic second_timer_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // both write halves taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_RESP: assert property (s_wr_take |-> ##[1:4] s_axi_bvalid)
    else $error("write got no response");
  AST_RD_RESP: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read got no data");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during data");
  AST_IRQ0_PULSE: assert property (first_timer_irq |=> !first_timer_irq)
    else $error("timer 0 request longer than a cycle");
  AST_IRQ1_PULSE: assert property (second_timer_irq |=> !second_timer_irq)
    else $error("timer 1 request longer than a cycle");
endmodule

bind dti_timer dti_timer_checker i_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .first_timer_irq(first_timer_irq), .second_timer_irq(second_timer_irq));

/* tb/test_dual_8bit_interval_timer.sv */
`timescale 1ns/1ps
`include "dti_cfg.svh"
// ==========================================
// bench signals and clocks
module test_dual_8bit_interval_timer;
  import dti_pkg::*;
  // byte address is four times the index
  localparam logic [7:0] A_RUN = 8'(`DTI_IDX_RUN * 4);
  localparam logic [7:0] A_LOW = 8'(`DTI_IDX_LOW_CMP * 4);
  localparam logic [7:0] A_HIGH = 8'(`DTI_IDX_HIGH_CMP * 4);
  localparam logic [7:0] A_MODE = 8'(`DTI_IDX_MODE * 4);
  localparam logic [7:0] A_TOG = 8'(`DTI_IDX_TOGGLE * 4);
  localparam logic [7:0] A_SYS = 8'(`DTI_IDX_SYSCLK * 4);
  localparam logic [7:0] A_STAT = 8'(`DTI_IDX_STATUS * 4);
  localparam logic [1:0] OK = `DTI_RESP_OKAY;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic geared_clock = 1'b0;
  logic low_osc = 1'b0;
  logic high_osc = 1'b0;
  logic ext_count_in = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic shared_toggle_ff, first_timer_irq, second_timer_irq;
  logic [31:0] d;
  logic [1:0] r;
  logic t;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #2.5 aclk = ~aclk;
  // geared and high sources rise every 2 cycles, low every 4
  always @(posedge aclk) begin
    geared_clock <= ~geared_clock;
    high_osc <= ~high_osc;
    if (geared_clock) low_osc <= ~low_osc;
  end

  dti_timer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .geared_clock(geared_clock), .low_osc(low_osc),
    .high_osc(high_osc), .ext_count_in(ext_count_in), .shared_toggle_ff(shared_toggle_ff),
    .first_timer_irq(first_timer_irq), .second_timer_irq(second_timer_irq));

  // ==========================================
  // reporting and bus tasks
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // hang guard, whole run needs well under this
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 100000) begin
      bad_count++;
      wrap_up();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  // both halves offered together, each released once taken
  task wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] e);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, v};
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // ready follows the response, so the slave must hold it a cycle
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    chk("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    chk("rresp", {30'h0, e}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
  endtask

  // stop and clear both timers, then set up and start
  task cfg(input logic [7:0] m, input logic [7:0] c0, input logic [7:0] c1,
           input logic [7:0] run);
    wr(A_RUN, 8'h80, OK);
    wr(A_MODE, m, OK);
    wr(A_LOW, c0, OK);
    wr(A_HIGH, c1, OK);
    wr(A_RUN, run, OK);
  endtask

  // cycles between two consecutive requests of one timer
  task meas(input bit sel, input int e, input string nm);
    int c;
    c = 0;
    do @(posedge aclk); while ((sel ? second_timer_irq : first_timer_irq) !== 1'b1);
    do begin
      @(posedge aclk);
      c++;
    end while ((sel ? second_timer_irq : first_timer_irq) !== 1'b1);
    chk(nm, e, c);
  endtask

  // ==========================================
  // scenarios
  task t_reset;
    // lane 0 strobe off: the write must leave run at its reset value
    s_axi_wstrb <= 4'hE;
    wr(A_RUN, 8'h81, OK);
    s_axi_wstrb <= 4'hF;
    rd(A_RUN, OK);
    chk("run reset", 32'h0, d);
    rd(A_MODE, OK);
    chk("mode reset", 32'h0, d);
    rd(A_TOG, OK);
    chk("toggle reset", 32'h3, d);
    rd(A_SYS, OK);
    chk("source reset", 32'h0, d);
    wr(A_LOW, 8'h55, OK);
    rd(A_LOW, OK);
    chk("compare readback", 32'h0, d);
    wr(8'hFC, 8'h00, `DTI_RESP_SLVERR);
    rd(8'hFC, `DTI_RESP_SLVERR);
  endtask

  task t_src;
    for (int i = 1; i < 4; i++) begin
      cfg(8'(i), 8'h01, 8'h00, 8'h81);
      meas(0, 16 << (2 * (i - 1)), "t0 tick period");
      cfg(8'(i * 4), 8'h00, 8'h01, 8'h82);
      meas(1, 16 << (4 * (i - 1)), "t1 tick period");
    end
    for (int s = 0; s < 3; s++) begin
      wr(A_SYS, 8'(s), OK);
      cfg(8'h01, 8'h01, 8'h00, 8'h81);
      meas(0, (s == 0) ? 16 : (s == 1) ? 32 : 256, "source period");
    end
    wr(A_SYS, 8'h00, OK);
  endtask

  task t_match;
    wr(A_TOG, 8'h07, OK);
    cfg(8'h01, 8'h03, 8'h00, 8'h81);
    meas(0, 48, "compare 3 period");
    t = shared_toggle_ff;
    do @(posedge aclk); while (first_timer_irq !== 1'b1);
    chk("toggle on match", {31'h0, ~t}, {31'h0, shared_toggle_ff});
    wr(A_TOG, 8'h03, OK);
    cfg(8'h01, 8'h00, 8'h00, 8'h81);
    meas(0, 4096, "compare zero period");
    cfg(8'h01, 8'h02, 8'h03, 8'h83);
    meas(1, 96, "t1 on t0 match");
  endtask

  task t_force;
    logic [7:0] code [4];
    logic exp [4];
    code = '{8'h01, 8'h02, 8'h00, 8'h00};
    exp = '{1'b0, 1'b1, 1'b0, 1'b1};
    wr(A_RUN, 8'h80, OK);
    for (int i = 0; i < 4; i++) begin
      wr(A_TOG, code[i], OK);
      chk("forced toggle", {31'h0, exp[i]}, {31'h0, shared_toggle_ff});
    end
    wr(A_TOG, 8'h03, OK);
  endtask

  task t_cascade;
    wr(A_RUN, 8'h80, OK);
    wr(A_MODE, 8'h11, OK);
    wr(A_LOW, 8'h02, OK);
    rd(A_STAT, OK);
    chk("suspended", 32'h1, {31'h0, d[17]});
    wr(A_HIGH, 8'h01, OK);
    rd(A_STAT, OK);
    chk("resumed", 32'h0, {31'h0, d[17]});
    wr(A_RUN, 8'h83, OK);
    meas(1, 4128, "cascade period");
  endtask

  // three pin rising edges, one match each
  task t_ext;
    int n;
    n = 0;
    cfg(8'h00, 8'h01, 8'h00, 8'h81);
    for (int j = 0; j < 30; j++) begin
      @(posedge aclk);
      ext_count_in <= (j % 8 < 4) && (j < 24);
      n += int'(first_timer_irq);
    end
    chk("pin matches", 32'd3, n);
  endtask

  task t_stop;
    cfg(8'h01, 8'h00, 8'h00, 8'h81);
    repeat (100) @(posedge aclk);
    wr(A_RUN, 8'h80, OK);
    rd(A_STAT, OK);
    chk("stopped count", 32'h0, {24'h0, d[7:0]});
    wr(A_RUN, 8'h01, OK);
    repeat (200) @(posedge aclk);
    rd(A_STAT, OK);
    chk("halted prescaler", 32'h0, {24'h0, d[7:0]});
  endtask

  // buffered write stays in the buffer in timer mode
  task t_dbuf;
    cfg(8'h01, 8'h01, 8'h00, 8'h81);
    wr(A_TOG, 8'h43, OK);
    wr(A_LOW, 8'h03, OK);
    meas(0, 16, "buffered period");
    wr(A_TOG, 8'h03, OK);
    wr(A_LOW, 8'h03, OK);
    meas(0, 48, "direct period");
  endtask

  // pulse modes; a buffered duty above the cycle must silence matches
  task t_pulse;
    int n;
    n = 0;
    cfg(8'h21, 8'h01, 8'h04, 8'h81);
    meas(0, 64, "ppg cycle");
    wr(A_TOG, 8'h43, OK);
    wr(A_LOW, 8'h05, OK);
    repeat (100) @(posedge aclk);
    repeat (200) begin
      @(posedge aclk);
      n += int'(first_timer_irq);
    end
    chk("ppg buffered duty", 32'd0, n);
    wr(A_TOG, 8'h03, OK);
    cfg(8'h31, 8'h10, 8'h00, 8'h81);
    meas(0, 4096, "pwm period");
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_src();
    t_match();
    t_force();
    t_cascade();
    t_ext();
    t_stop();
    t_dbuf();
    t_pulse();
    wrap_up();
  end
endmodule
